/* File: rtl/sprog_ctrl.sv */
// Self-programming control register, readback arming and write timing.
`timescale 1ns/10ps
`include "sprog_defs.svh"
module sprog_ctrl #(
	parameter int WRITE_CYCLES = `SPROG_WRITE_CYCLES,
	parameter int NO_READ_WHILE_WRITE_SECTION_START = 16'hf000
) (
	input wire logic clk, // Clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic ctrl_wr, // Pulse: CPU writes the control register.
	input wire sprog_pkg::sprog_byte_t ctrl_wdata, // Value written.
	output sprog_pkg::sprog_byte_t ctrl_rdata, // Control register read value.
	input wire logic eeprom_write_busy, // EEPROM write in progress.
	input wire logic store_exec, // Pulse: store-program instruction.
	input wire logic program_memory_load, // Pulse: load instruction.
	input wire logic [15:0] addr_ptr, // Address pointer.
	input wire sprog_pkg::sprog_byte_t flash_rdata, // Ordinary flash byte.
	input wire sprog_pkg::sprog_byte_t lock_byte, // Lock bits, 0 = programmed.
	input wire sprog_pkg::sprog_byte_t fuse_low_byte, // Low fuse byte.
	input wire sprog_pkg::sprog_byte_t fuse_high_byte, // High fuse byte.
	input wire sprog_pkg::sprog_byte_t fuse_extended_byte, // Extended fuse byte.
	output sprog_pkg::sprog_byte_t load_rdata, // Destination value of a load.
	output logic load_valid, // Pulse: load_rdata is fresh.
	output logic load_was_fuse, // Last load was a fuse or lock readback.
	output logic flash_op_start, // Pulse: a programming operation starts.
	output sprog_pkg::sprog_op_e flash_op, // Operation that was started.
	output logic buffer_load, // Pulse: page buffer word load.
	input wire logic [15:0] fetch_addr, // Instruction fetch word address.
	output logic fetch_allowed // Fetch may proceed.
);
	import sprog_pkg::*;

	logic cmd_en_reg, lock_set_reg, erase_reg, write_reg, rww_re_reg, int_en_reg;
	logic rww_busy_reg;
	logic [2:0] age_reg;
	logic [2:0] age_next;
	logic op_busy;
	logic rww_op_reg;
	sprog_op_e op_reg;
	sprog_byte_t rdata_reg;
	logic valid_reg, fuse_reg;

	// Decode of software writes and the armed readback window.
	wire ctrl_wr_ok = ctrl_wr && !eeprom_write_busy && !op_busy; // RULE_01 RULE_02
	wire armed = cmd_en_reg && lock_set_reg && !op_busy;
	wire load_window = age_reg < 3'(`SPROG_LOAD_WINDOW);
	wire store_window = age_reg < 3'(`SPROG_STORE_WINDOW);
	wire fuse_read = armed && program_memory_load && load_window && !eeprom_write_busy; // RULE_02
	wire store_ok = cmd_en_reg && !op_busy && store_exec && store_window;
	wire do_erase = store_ok && erase_reg;
	wire do_write = store_ok && write_reg;
	wire do_lock = store_ok && lock_set_reg;
	wire do_load = store_ok && !erase_reg && !write_reg && !lock_set_reg && !rww_re_reg;
	wire do_rww_re = store_ok && rww_re_reg;
	wire timed_start = do_erase || do_write || do_lock;
	wire arm_expire = cmd_en_reg && !op_busy && !store_window; // RULE_05
	wire arm_done = fuse_read || (store_ok && !timed_start); // RULE_05 RULE_19
	wire rww_target = addr_ptr < 16'(NO_READ_WHILE_WRITE_SECTION_START);

	// Age of the armed command, counted from the register write.
	assign age_next = ctrl_wr_ok ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);

	// Readback multiplexer, bits pass one to one.
	wire [7:0] fuse_sel = (addr_ptr == `SPROG_ADDR_LOCK) ? lock_byte : // RULE_04
		(addr_ptr == `SPROG_ADDR_FUSE_HIGH) ? fuse_high_byte : // RULE_08
		(addr_ptr == `SPROG_ADDR_FUSE_EXT) ? fuse_extended_byte : // RULE_09
		fuse_low_byte; // RULE_07 RULE_10
	wire [7:0] load_next = fuse_read ? fuse_sel : flash_rdata; // RULE_06

	sprog_timer #(
		.CYCLES(WRITE_CYCLES)
	) u_timer (
		.clk(clk),
		.srst(srst),
		.start(timed_start),
		.busy(op_busy)
	);

	// Control bits: set by software; all but int_en_reg cleared by completion or timeout.
	always_ff @(posedge clk) begin
		if (srst) begin
			{int_en_reg, rww_re_reg, lock_set_reg, write_reg, erase_reg, cmd_en_reg} <= 6'h00;
		end else if (ctrl_wr_ok) begin
			int_en_reg <= ctrl_wdata[`SPROG_BIT_INT_EN];
			rww_re_reg <= ctrl_wdata[`SPROG_BIT_RWW_RE];
			lock_set_reg <= ctrl_wdata[`SPROG_BIT_LOCK_SET];
			write_reg <= ctrl_wdata[`SPROG_BIT_PAGE_WRITE];
			erase_reg <= ctrl_wdata[`SPROG_BIT_PAGE_ERASE];
			cmd_en_reg <= ctrl_wdata[`SPROG_BIT_CMD_EN];
		end else if (arm_done || arm_expire || (rww_op_reg && !op_busy && !timed_start)) begin
			{rww_re_reg, lock_set_reg, write_reg, erase_reg, cmd_en_reg} <= 5'h00; // RULE_05
		end
	end

	// Command age; reset loads 7.
	always_ff @(posedge clk) begin
		if (srst) begin
			age_reg <= 3'h7;
		end else begin
			age_reg <= age_next;
		end
	end

	// Running operation kind; a reset leaves it alone while the timed write finishes.
	always_ff @(posedge clk) begin
		if (srst && !op_busy) begin // RULE_11
			op_reg <= SPROG_OP_NONE;
			rww_op_reg <= 1'b0;
		end else if (timed_start) begin
			op_reg <= do_lock ? SPROG_OP_LOCK : (do_erase ? SPROG_OP_ERASE : SPROG_OP_WRITE);
			rww_op_reg <= 1'b1;
		end else if (!op_busy) begin
			rww_op_reg <= 1'b0;
		end
	end

	// Section busy flag: set by erase or write to the section, cleared on re-enable or load.
	always_ff @(posedge clk) begin
		if (srst) begin
			rww_busy_reg <= 1'b0;
		end else if ((do_erase || do_write) && rww_target) begin
			rww_busy_reg <= 1'b1;
		end else if (do_rww_re || do_load) begin
			rww_busy_reg <= 1'b0; // RULE_18
		end
	end

	// Load destination register.
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 8'h00;
			valid_reg <= 1'b0;
			fuse_reg <= 1'b0;
		end else begin
			valid_reg <= program_memory_load;
			if (program_memory_load) begin
				rdata_reg <= load_next;
				fuse_reg <= fuse_read;
			end
		end
	end

	// Outputs.
	wire erase_or_write = op_busy && (op_reg == SPROG_OP_ERASE || op_reg == SPROG_OP_WRITE);
	assign fetch_allowed = !erase_or_write || fetch_addr >= 16'(NO_READ_WHILE_WRITE_SECTION_START); // RULE_17
	assign ctrl_rdata = {int_en_reg, rww_busy_reg, 1'b0, rww_re_reg, lock_set_reg, write_reg,
		erase_reg, cmd_en_reg | op_busy};
	assign load_rdata = rdata_reg;
	assign load_valid = valid_reg;
	assign load_was_fuse = fuse_reg;
	assign flash_op_start = timed_start;
	assign flash_op = op_reg;
	assign buffer_load = do_load;
endmodule

/* File: rtl/sprog_defs.svh */
// Constants for the self-programming access controller.
// How it works
// RULE_01 - EEPROM write busy refuses flash programming commands
// RULE_02 - EEPROM write busy refuses fuse and lock readback
// RULE_03 - Software waits for EEPROM idle first
// RULE_04 - Pointer one plus armed load returns lock byte
// RULE_05 - Arm bits clear on completion or timeout
// RULE_06 - Disarmed load performs ordinary flash read
// RULE_07 - Pointer zero returns fuse low byte
// RULE_08 - Pointer three returns fuse high byte
// RULE_09 - Pointer two returns fuse extended byte
// RULE_10 - Programmed bits read zero, unprogrammed read one
// RULE_11 - Running flash write survives reset
// RULE_12 - Erase, write, lock write take 3.7-4.5ms
// RULE_13 - Software polls command enable clear first
// RULE_14 - Software writes command then store immediately
// RULE_15 - Software erase, re-enable, load, write, re-enable
// RULE_16 - Software rechecks section busy before returning
// RULE_17 - During erase/write fetch only from boot section
// RULE_18 - Section busy clears on re-enable or load
// RULE_19 - Each armed readback is one-shot
`ifndef SPROG_DEFS_SVH
`define SPROG_DEFS_SVH
`define SPROG_BIT_CMD_EN 0
`define SPROG_BIT_PAGE_ERASE 1
`define SPROG_BIT_PAGE_WRITE 2
`define SPROG_BIT_LOCK_SET 3
`define SPROG_BIT_RWW_RE 4
`define SPROG_BIT_RWW_BUSY 6
`define SPROG_BIT_INT_EN 7
`define SPROG_CTRL_RESET 8'h00
`define SPROG_ADDR_FUSE_LOW 16'h0000
`define SPROG_ADDR_LOCK 16'h0001
`define SPROG_ADDR_FUSE_EXT 16'h0002
`define SPROG_ADDR_FUSE_HIGH 16'h0003
`define SPROG_LOAD_WINDOW 3
`define SPROG_STORE_WINDOW 4
`define SPROG_CLK_MHZ 250
`define SPROG_WRITE_MIN_US 3700
`define SPROG_WRITE_MAX_US 4500
`define SPROG_WRITE_CYCLES ((`SPROG_WRITE_MIN_US * `SPROG_CLK_MHZ + `SPROG_WRITE_MAX_US * `SPROG_CLK_MHZ) / 2)
`endif

/* File: rtl/sprog_pkg.sv */
// Types shared by the self-programming access controller.
package sprog_pkg;
	typedef enum logic [1:0] {
		SPROG_OP_NONE,
		SPROG_OP_ERASE,
		SPROG_OP_WRITE,
		SPROG_OP_LOCK
	} sprog_op_e;
	typedef logic [7:0] sprog_byte_t;
endpackage

/* File: rtl/sprog_timer.sv */
// Down counter that times one flash write operation.
`timescale 1ns/10ps
module sprog_timer #(
	parameter int CYCLES = 1000000
) (
	input wire logic clk, // Clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic start, // Pulse that begins a timed operation.
	output logic busy // High while the operation runs.
);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic busy_next;

	// Load on start, count down to zero; reset does not abort a running write.
	assign count_next = start ? 32'(CYCLES) : (count_reg != 32'h0 ? count_reg - 32'h1 : 32'h0);
	assign busy_next = count_next != 32'h0;

	// A reset leaves a running count alone so the write completes.
	always_ff @(posedge clk) begin
		if (srst && !busy) begin // RULE_11
			count_reg <= 32'h0;
		end else begin
			count_reg <= count_next; // RULE_12
		end
	end

	always_ff @(posedge clk) begin
		if (srst && !busy) begin
			busy <= 1'b0;
		end else begin
			busy <= busy_next;
		end
	end
endmodule

/* File: tb/sprog_ctrl_props.sv */
// Concurrent checks on the self-programming controller ports.
`timescale 1ns/10ps
module sprog_ctrl_props #(
	parameter int WRITE_CYCLES = 20,
	parameter int NO_READ_WHILE_WRITE_SECTION_START = 16'hf000
) (
	input wire logic clk, // Clock.
	input wire logic srst, // Reset.
	input wire logic ctrl_wr, // Control write.
	input wire sprog_pkg::sprog_byte_t ctrl_wdata, // Written value.
	input wire sprog_pkg::sprog_byte_t ctrl_rdata, // Control value.
	input wire logic eeprom_write_busy, // EEPROM busy.
	input wire logic store_exec, // Store pulse.
	input wire logic program_memory_load, // Load pulse.
	input wire logic [15:0] addr_ptr, // Pointer.
	input wire sprog_pkg::sprog_byte_t flash_rdata, // Flash byte.
	input wire sprog_pkg::sprog_byte_t lock_byte, // Lock byte.
	input wire sprog_pkg::sprog_byte_t fuse_low_byte, // Low fuses.
	input wire sprog_pkg::sprog_byte_t fuse_high_byte, // High fuses.
	input wire sprog_pkg::sprog_byte_t fuse_extended_byte, // Extended fuses.
	input wire sprog_pkg::sprog_byte_t load_rdata, // Load result.
	input wire logic load_valid, // Load done.
	input wire logic load_was_fuse, // Fuse readback.
	input wire logic flash_op_start, // Operation start.
	input wire sprog_pkg::sprog_op_e flash_op, // Operation kind.
	input wire logic [15:0] fetch_addr, // Fetch address.
	input wire logic fetch_allowed // Fetch grant.
);
	import sprog_pkg::*;
	int cnt_reg = 0;
	// Tracks a timed operation; reset leaves it running as the flash does.
	always_ff @(posedge clk) begin
		cnt_reg <= flash_op_start ? WRITE_CYCLES - 2 : (cnt_reg > 0 ? cnt_reg - 1 : 0);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// A readback arming write that the block accepts.
	sequence seq_arm;
		ctrl_wr && ctrl_wdata == 8'h09 && !eeprom_write_busy && !ctrl_rdata[0];
	endsequence
	property fuse_rd(logic [15:0] a, sprog_byte_t b);
		seq_arm ##[1:3] (program_memory_load && ctrl_rdata[3] && addr_ptr == a && !eeprom_write_busy)
			|=> load_was_fuse && load_rdata == $past(b) && !ctrl_rdata[3];
	endproperty
	lock_read_a: assert property (fuse_rd(16'h0001, lock_byte)) else $error("lock read");
	fuse_low_a: assert property (fuse_rd(16'h0000, fuse_low_byte)) else $error("low fuse");
	fuse_ext_a: assert property (fuse_rd(16'h0002, fuse_extended_byte)) else $error("ext");
	fuse_high_a: assert property (fuse_rd(16'h0003, fuse_high_byte)) else $error("high");
	arm_timeout_a: assert property (seq_arm ##1 (!program_memory_load && !store_exec && !ctrl_wr)[*5]
		|=> !ctrl_rdata[3]) else $error("arm kept");
	ee_refuse_a: assert property (ctrl_wr && eeprom_write_busy && !ctrl_rdata[0]
		|=> !ctrl_rdata[0]) else $error("write taken");
	ee_noread_a: assert property (program_memory_load && eeprom_write_busy
		|=> load_valid && !load_was_fuse) else $error("fuse read");
	plain_read_a: assert property (program_memory_load && !(ctrl_rdata[3] && ctrl_rdata[0])
		|=> load_valid && !load_was_fuse && load_rdata == $past(flash_rdata)) else $error("plain");
	op_busy_a: assert property (cnt_reg > 0 |-> ctrl_rdata[0]) else $error("op ended");
	fetch_guard_a: assert property (cnt_reg > 0 && flash_op != SPROG_OP_LOCK && fetch_addr < NO_READ_WHILE_WRITE_SECTION_START
		|-> !fetch_allowed) else $error("fetch");
endmodule
bind sprog_ctrl sprog_ctrl_props #(.WRITE_CYCLES(WRITE_CYCLES), .NO_READ_WHILE_WRITE_SECTION_START(NO_READ_WHILE_WRITE_SECTION_START)) u_props (
	.clk, .srst, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .eeprom_write_busy, .store_exec,
	.program_memory_load, .addr_ptr, .flash_rdata, .lock_byte, .fuse_low_byte, .fuse_high_byte,
	.fuse_extended_byte, .load_rdata, .load_valid, .load_was_fuse, .flash_op_start, .flash_op,
	.fetch_addr, .fetch_allowed);

/* File: tb/sprog_cpu_model.sv */
// CPU core model issuing control writes, stores and loads.
`timescale 1ns/10ps
module sprog_cpu_model (
	input wire logic clk, // Clock.
	input wire sprog_pkg::sprog_byte_t ctrl_rdata, // Control value.
	output logic ctrl_wr = 0, // Control write.
	output sprog_pkg::sprog_byte_t ctrl_wdata = 0, // Written value.
	output logic store_exec = 0, // Store pulse.
	output logic program_memory_load = 0 // Load pulse.
);
	import sprog_pkg::*;
	// Writes the control register once idle, then stores at once if asked.
	task automatic cmd(input sprog_byte_t v, input logic st);
		while (ctrl_rdata[0] === 1'b1) @(negedge clk);
		@(negedge clk);
		ctrl_wr = 1;
		ctrl_wdata = v;
		@(negedge clk);
		ctrl_wr = 0;
		ctrl_wdata = ~v;
		store_exec = st;
		if (st) begin
			@(negedge clk);
			store_exec = 0;
		end
	endtask
	// Issues one load on the d-th edge from now.
	task automatic load(input int d);
		repeat (d - 1) @(negedge clk);
		program_memory_load = 1;
		@(negedge clk);
		program_memory_load = 0;
	endtask
endmodule

/* File: tb/test_selfprog_fuse_lock_readback.sv */
// Bench for the self-programming controller.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module test_selfprog_fuse_lock_readback;
	import sprog_pkg::*;
	logic clk = 0;
	logic srst = 1;
	logic eeprom_write_busy = 0;
	logic [15:0] addr_ptr = 0;
	logic [15:0] fetch_addr = 0;
	sprog_byte_t flash_rdata = 0;
	sprog_byte_t fb[4] = '{default: 8'h00};
	logic ctrl_wr, store_exec, program_memory_load, load_valid, load_was_fuse, fetch_allowed;
	sprog_byte_t ctrl_wdata, ctrl_rdata, load_rdata;
	sprog_op_e flash_op;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	integer seed = 32'hb75482c9;
	logic [8:0] exp_q[$];
	logic [8:0] exp_v;
	sprog_ctrl #(.WRITE_CYCLES(20)) u_dut (.clk, .srst, .ctrl_wr, .ctrl_wdata, .ctrl_rdata,
		.eeprom_write_busy, .store_exec, .program_memory_load, .addr_ptr, .flash_rdata,
		.lock_byte(fb[1]), .fuse_low_byte(fb[0]), .fuse_high_byte(fb[3]),
		.fuse_extended_byte(fb[2]), .load_rdata, .load_valid, .load_was_fuse,
		.flash_op_start(), .flash_op, .buffer_load(), .fetch_addr, .fetch_allowed);
	sprog_cpu_model u_cpu (.clk, .ctrl_rdata, .ctrl_wr, .ctrl_wdata, .store_exec,
		.program_memory_load);
	always #2 clk = ~clk;
	// Compares each load result with the oldest noted expectation.
	always @(negedge clk) begin
		if (load_valid === 1'b1) begin
			exp_v = exp_q.pop_front();
			`CHK({load_was_fuse, load_rdata}, exp_v)
		end
	end
	// Cuts a hang short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Notes the expected result, then has the core issue the load.
	task automatic rd(input int d, input logic [8:0] e);
		exp_q.push_back(e);
		u_cpu.load(d);
	endtask
	// Waits for the timed operation to end and counts its cycles.
	task automatic wait_op(output int n);
		for (n = 0; ctrl_rdata[0] !== 1'b0 && n < 100; n++) @(negedge clk);
	endtask
	// Readback, refusal and timed operation sequences.
	initial begin
		int i;
		flash_rdata = 8'($random(seed));
		repeat (16) @(negedge clk);
		srst = 0;
		for (i = 0; i < 4; i++) begin
			fb[i] = 8'($random(seed));
			addr_ptr = 16'(i);
			u_cpu.cmd(8'h09, 1'b0);
			rd(i % 3 + 1, {1'b1, fb[i]});
			rd(2, {1'b0, flash_rdata});
		end
		u_cpu.cmd(8'h09, 1'b0);
		repeat (5) @(negedge clk);
		rd(1, {1'b0, flash_rdata});
		eeprom_write_busy = 1;
		u_cpu.cmd(8'h09, 1'b0);
		`CHK(ctrl_rdata[0], 1'b0)
		rd(1, {1'b0, flash_rdata});
		eeprom_write_busy = 0;
		addr_ptr = 16'h0100;
		fetch_addr = 16'h0040;
		u_cpu.cmd(8'h03, 1'b1);
		`CHK(fetch_allowed, 1'b0)
		`CHK(flash_op, SPROG_OP_ERASE)
		`CHK(ctrl_rdata[6], 1'b1)
		fetch_addr = 16'hf010;
		wait_op(i);
		`CHK(i inside {[14:22]}, 1'b1)
		`CHK(ctrl_rdata[6], 1'b1)
		u_cpu.cmd(8'h11, 1'b1);
		`CHK(ctrl_rdata[6], 1'b0)
		u_cpu.cmd(8'h05, 1'b1);
		repeat (5) @(negedge clk);
		fetch_addr = 16'h0040;
		srst = 1;
		@(negedge clk);
		srst = 0;
		`CHK(ctrl_rdata[0], 1'b1)
		`CHK(fetch_allowed, 1'b0)
		`CHK(flash_op, SPROG_OP_WRITE)
		wait_op(i);
		end_sim();
	end
endmodule
